// ---- verilog/slave_info_pkg.sv ----
// constants shared by the slave information store and its power-up loader
// assumes a 16-bit word organised store and an AXI4-Lite register window of eight words
package slave_info_pkg;

  // store geometry
  localparam int STORE_BITS = 16384;                      // capacity in bits
  localparam int WORD_BITS  = 16;                         // every location is one 16-bit word
  localparam int STORE_WORDS = STORE_BITS / WORD_BITS;    // number of word locations
  localparam int STORE_AW   = $clog2(STORE_WORDS);        // word address width

  // word addresses inside the store
  localparam logic [STORE_AW-1:0] WA_IF_CTRL    = 10'h000; // process data interface control pair
  localparam logic [STORE_AW-1:0] WA_IF_CFG     = 10'h001; // interface configuration pair
  localparam logic [STORE_AW-1:0] WA_SYNC_PULSE = 10'h002; // sync pulse length
  localparam logic [STORE_AW-1:0] WA_EXT_CFG    = 10'h003; // extended interface configuration
  localparam logic [STORE_AW-1:0] WA_ALIAS      = 10'h004; // station alias word
  localparam logic [STORE_AW-1:0] WA_CSUM       = 10'h007; // checksum over words 0..6
  localparam logic [STORE_AW-1:0] WA_IDENT      = 10'h008; // vendor, product, revision, serial
  localparam logic [STORE_AW-1:0] WA_SIZE       = 10'h03e; // capacity code
  localparam logic [STORE_AW-1:0] WA_VERSION    = 10'h03f; // layout version
  localparam logic [STORE_AW-1:0] WA_CATEGORY   = 10'h040; // first categorised word

  // factory contents of the configuration area, size and version words, erased word
  localparam logic [15:0] DEF_IF_CTRL    = 16'h0c05;
  localparam logic [15:0] DEF_IF_CFG     = 16'h6603;
  localparam logic [15:0] DEF_SYNC_PULSE = 16'h0064;
  localparam logic [15:0] DEF_EXT_CFG    = 16'h0000;
  localparam logic [15:0] DEF_ALIAS      = 16'h0000;
  localparam logic [15:0] DEF_RESERVED   = 16'h0000;
  localparam logic [15:0] DEF_SIZE       = 16'h000f;
  localparam logic [15:0] DEF_VERSION    = 16'h0001;
  localparam logic [15:0] DEF_EMPTY      = 16'hffff; // erased word, also the category end marker

  // controller core built-in values, independent of the store
  localparam logic [15:0] CORE_IF_CTRL    = 16'h0c05;
  localparam logic [15:0] CORE_IF_CFG     = 16'h6603;
  localparam logic [15:0] CORE_SYNC_PULSE = 16'h0000;
  localparam logic [15:0] CORE_EXT_CFG    = 16'h0000;
  localparam logic [15:0] ALIAS_RESET     = 16'h0000;

  // checksum: crc-8 over the low then high byte of words 0..6
  localparam logic [7:0] CRC_INIT = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // register window, byte addresses
  localparam logic [7:0] OFS_STORE_ADDR = 8'h00;
  localparam logic [7:0] OFS_STORE_DATA = 8'h04;
  localparam logic [7:0] OFS_STATUS     = 8'h08;
  localparam logic [7:0] OFS_ALIAS      = 8'h0c;
  localparam logic [7:0] OFS_IF_CTRL    = 8'h10;
  localparam logic [7:0] OFS_IF_CFG     = 8'h14;
  localparam logic [7:0] OFS_SYNC_PULSE = 8'h18;
  localparam logic [7:0] OFS_EXT_CFG    = 8'h1c;
  localparam logic [7:0] OFS_LIMIT      = 8'h20; // first unmapped byte address

  // status register bits
  localparam int ST_BUSY    = 0;
  localparam int ST_DONE    = 1;
  localparam int ST_CSUM_OK = 2;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // one crc-8 step over a byte, msb first
  function automatic logic [7:0] crc8_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    end
    return c;
  endfunction

  // crc-8 over one whole word, low byte first
  function automatic logic [7:0] crc8_word(input logic [7:0] crc, input logic [15:0] word);
    return crc8_byte(crc8_byte(crc, word[7:0]), word[15:8]);
  endfunction

endpackage

// ---- verilog/slave_info_store.sv ----
// word organised nonvolatile store holding the slave description data
// assumes one port shared by loader and software; read data registered, one cycle late
`timescale 1ns/1ps
`default_nettype none
module slave_info_store import slave_info_pkg::*; #(
  parameter logic [31:0] VENDOR_ID    = 32'h0000_0a5a, // arbitrary value
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001,
  parameter logic [31:0] REVISION     = 32'h0000_0001,
  parameter logic [31:0] SERIAL       = 32'h0000_0000
) (
  input  wire logic                clk,
  input  wire logic [STORE_AW-1:0] addr,
  input  wire logic [1:0]          byte_we,
  input  wire logic [15:0]         wdata,
  output logic      [15:0]         rdata
);

  logic [15:0] mem [STORE_WORDS];  // the cells, no reset: contents survive power cycles
  logic [7:0]  crc;                // checksum of the factory image

  // factory image: configuration area, identity, size code, empty categories
  initial begin
    for (int i = 0; i < STORE_WORDS; i++) begin
      mem[i] = DEF_EMPTY;
    end
    mem[WA_IF_CTRL]    = DEF_IF_CTRL;
    mem[WA_IF_CFG]     = DEF_IF_CFG;
    mem[WA_SYNC_PULSE] = DEF_SYNC_PULSE;
    mem[WA_EXT_CFG]    = DEF_EXT_CFG;
    mem[WA_ALIAS]      = DEF_ALIAS;
    mem[WA_ALIAS + 10'h001] = DEF_RESERVED; // reserved, no function
    mem[WA_ALIAS + 10'h002] = DEF_RESERVED;
    crc = CRC_INIT;
    for (int i = 0; i < int'(WA_CSUM); i++) begin
      crc = crc8_word(crc, mem[i]);
    end
    mem[WA_CSUM] = {8'h00, crc};
    // identity fields, low word first
    mem[WA_IDENT]          = VENDOR_ID[15:0];
    mem[WA_IDENT + 10'h001] = VENDOR_ID[31:16];
    mem[WA_IDENT + 10'h002] = PRODUCT_CODE[15:0];
    mem[WA_IDENT + 10'h003] = PRODUCT_CODE[31:16];
    mem[WA_IDENT + 10'h004] = REVISION[15:0];
    mem[WA_IDENT + 10'h005] = REVISION[31:16];
    mem[WA_IDENT + 10'h006] = SERIAL[15:0];
    mem[WA_IDENT + 10'h007] = SERIAL[31:16];
    mem[WA_SIZE]    = DEF_SIZE;
    mem[WA_VERSION] = DEF_VERSION;
  end

  // byte-lane writes and registered read
  // plain always: the factory image block writes these cells too
  always @(posedge clk) begin
    if (byte_we[0]) begin
      mem[addr][7:0] <= wdata[7:0];
    end
    if (byte_we[1]) begin
      mem[addr][15:8] <= wdata[15:8];
    end
    rdata <= mem[addr];
  end

endmodule // slave_info_store
`default_nettype wire

// ---- verilog/slave_info_eeprom_loader.sv ----
// slave information store with power-up alias loader and an axi4-lite register window
// assumes SYS_RST is asserted once per control power-up; the store itself is not reset
//
// How it works
// RULE1: store holds 16 Kbit as 1024 words
// RULE2: every store location addressed per 16-bit word
// RULE3: after power-up, word 0004h loads alias register
// RULE4: alias changes apply only after power cycle
// RULE5: other controller registers keep core built-ins
// RULE6: writers change alias and checksum together
// RULE7: word 0007h checksums words 0000h..0006h
// RULE8: word 0000h defaults to 0C05h, interface control
// RULE9: word 0001h defaults to 6603h, interface config
// RULE10: word 0002h defaults to 0064h, sync pulse
// RULE11: word 0003h defaults to zero, extended config
// RULE12: alias defaults zero; words 0005h-0006h reserved
// RULE13: identity fields follow from word 0008h
// RULE14: categorised data starts at word 0040h
// RULE15: word 003Eh holds capacity code 000Fh
// RULE16: bad checksum leaves alias register at zero
`timescale 1ns/1ps
`default_nettype none
module slave_info_eeprom_loader import slave_info_pkg::*; #(
  parameter logic [31:0] VENDOR_ID    = 32'h0000_0a5a, // arbitrary value
  parameter logic [31:0] PRODUCT_CODE = 32'h0000_0001,
  parameter logic [31:0] REVISION     = 32'h0000_0001,
  parameter logic [31:0] SERIAL       = 32'h0000_0000
) (
  input  wire logic        CLK,
  input  wire logic        SYS_RST,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic [2:0]  S_AXI_AWPROT,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic [2:0]  S_AXI_ARPROT,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY,
  output logic             LOAD_DONE,
  output logic [15:0]      STATION_ALIAS
);

  // loader states
  typedef enum logic [1:0] {
    LD_ISSUE = 2'b00,  // address of the next word on the store port
    LD_TAKE  = 2'b01,  // registered read data arrive
    LD_DONE  = 2'b10   // idle until the next power-up
  } ld_state_e;

  // register window decode helpers
  function automatic logic is_mapped(input logic [7:0] a);
    return a < OFS_LIMIT;
  endfunction

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    return a[4:2];
  endfunction

  // loader state
  ld_state_e          ld_state_reg;   // current loader step
  ld_state_e          ld_state_next;
  logic [2:0]         ld_idx_reg;     // configuration word being read
  logic [7:0]         crc_reg;        // running checksum
  logic [15:0]        alias_cap_reg;  // alias word as read, applied only when checked
  logic               csum_ok_reg;    // checksum outcome of this power-up
  logic [15:0]        alias_reg;      // controller alias register image

  // bus state
  logic               aw_taken_reg;   // write address held
  logic               w_taken_reg;    // write data held
  logic [7:0]         awaddr_reg;
  logic [31:0]        wdata_reg;
  logic [3:0]         wstrb_reg;
  logic [7:0]         araddr_reg;
  logic [1:0]         rd_pipe_reg;    // read in flight, store data two edges away
  logic [STORE_AW-1:0] store_addr_reg; // software word pointer into the store

  // store port
  logic [STORE_AW-1:0] mem_addr;
  logic [1:0]          mem_we;
  logic [15:0]         mem_rdata;

  // loader datapath
  wire        loading   = (ld_state_reg != LD_DONE);
  wire        take_last = (ld_state_reg == LD_TAKE) && (ld_idx_reg == WA_CSUM[2:0]);
  wire        take_word = (ld_state_reg == LD_TAKE) && !take_last;
  wire [7:0]  crc_next  = crc8_word(crc_reg, mem_rdata);            // [RULE7]
  wire        csum_good = (mem_rdata[7:0] == crc_reg);              // [RULE7]

  // bus decode
  wire        wr_fire   = aw_taken_reg && w_taken_reg && !S_AXI_BVALID;
  wire        wr_mapped = is_mapped(awaddr_reg);
  wire [2:0]  wr_idx    = reg_index(awaddr_reg);
  wire        wr_data   = wr_fire && wr_mapped && (wr_idx == reg_index(OFS_STORE_DATA));
  wire        wr_ptr    = wr_fire && wr_mapped && (wr_idx == reg_index(OFS_STORE_ADDR));
  wire        ar_hs     = S_AXI_ARVALID && S_AXI_ARREADY;
  wire        aw_hs     = S_AXI_AWVALID && S_AXI_AWREADY;
  wire        w_hs      = S_AXI_WVALID && S_AXI_WREADY;
  // pointer bytes follow the write strobes, as a store word does
  wire [STORE_AW-1:0] ptr_next = {
    wstrb_reg[1] ? wdata_reg[STORE_AW-1:8] : store_addr_reg[STORE_AW-1:8],
    wstrb_reg[0] ? wdata_reg[7:0] : store_addr_reg[7:0]
  };

  // the store is word addressed: loader uses the word index, software the word pointer
  assign mem_addr = loading ? {{(STORE_AW-3){1'b0}}, ld_idx_reg} : store_addr_reg; // [RULE2]
  assign mem_we   = wr_data ? wstrb_reg[1:0] : 2'b00;                              // [RULE2] [RULE6]

  // loader sequencing
  always_comb begin
    ld_state_next = ld_state_reg;
    unique case (ld_state_reg)
      LD_ISSUE: ld_state_next = LD_TAKE;
      LD_TAKE:  ld_state_next = take_last ? LD_DONE : LD_ISSUE;
      LD_DONE:  ld_state_next = LD_DONE; // nothing reloads before the next reset [RULE4]
      default:  ld_state_next = LD_DONE;
    endcase
  end

  // read mux: store pointer, store word, status, alias, then core built-ins
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    // addresses past the window alias here; the data channel zeroes them
    unique case (reg_index(araddr_reg))
      3'h0: rd_mux = {{(32-STORE_AW){1'b0}}, store_addr_reg};
      3'h1: rd_mux = {16'h0000, mem_rdata};
      3'h2: begin
        rd_mux[ST_BUSY]    = loading;
        rd_mux[ST_DONE]    = !loading;
        rd_mux[ST_CSUM_OK] = csum_ok_reg;
      end
      3'h3: rd_mux = {16'h0000, alias_reg};
      3'h4: rd_mux = {16'h0000, CORE_IF_CTRL};    // [RULE5]
      3'h5: rd_mux = {16'h0000, CORE_IF_CFG};     // [RULE5]
      3'h6: rd_mux = {16'h0000, CORE_SYNC_PULSE}; // [RULE5]
      3'h7: rd_mux = {16'h0000, CORE_EXT_CFG};    // [RULE5]
    endcase
  end

  // the store with its factory image
  slave_info_store #(
    .VENDOR_ID    (VENDOR_ID),
    .PRODUCT_CODE (PRODUCT_CODE),
    .REVISION     (REVISION),
    .SERIAL       (SERIAL)
  ) u_store (
    .clk     (CLK),
    .addr    (mem_addr),
    .byte_we (mem_we),
    .wdata   (wdata_reg[15:0]),
    .rdata   (mem_rdata)
  ); // [RULE1] [RULE8] [RULE9] [RULE10] [RULE11] [RULE12] [RULE13] [RULE14] [RULE15]

  // loader state and word index; runs once per power-up
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ld_state_reg <= LD_ISSUE;
      ld_idx_reg   <= 3'h0;
    end else begin
      ld_state_reg <= ld_state_next;
      // the index stops at the checksum word, so it never wraps
      if (take_word) begin
        ld_idx_reg <= ld_idx_reg + 3'h1;
      end
    end
  end

  // checksum accumulation and alias capture over words 0..6
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      crc_reg       <= CRC_INIT;
      alias_cap_reg <= ALIAS_RESET;
    end else if (take_word) begin
      crc_reg <= crc_next; // [RULE7]
      if (ld_idx_reg == WA_ALIAS[2:0]) begin
        alias_cap_reg <= mem_rdata; // [RULE3]
      end
    end
  end

  // alias applied only if the checksum matches; zero otherwise
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      alias_reg     <= ALIAS_RESET;
      csum_ok_reg   <= 1'b0;
      STATION_ALIAS <= ALIAS_RESET;
      LOAD_DONE     <= 1'b0;
    end else if (take_last) begin
      // a failed check still ends the load, so the bus opens
      csum_ok_reg   <= csum_good;                               // [RULE16]
      alias_reg     <= csum_good ? alias_cap_reg : ALIAS_RESET; // [RULE3] [RULE16]
      STATION_ALIAS <= csum_good ? alias_cap_reg : ALIAS_RESET; // [RULE3] [RULE16]
      LOAD_DONE     <= 1'b1;
    end
  end

  // write address channel; refused while the loader owns the store port
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_AWREADY <= 1'b0;
      aw_taken_reg  <= 1'b0;
      awaddr_reg    <= 8'h00;
    end else begin
      S_AXI_AWREADY <= S_AXI_AWVALID && !S_AXI_AWREADY && !aw_taken_reg && !loading;
      if (aw_hs) begin
        aw_taken_reg <= 1'b1;
        awaddr_reg   <= S_AXI_AWADDR;
      end else if (wr_fire) begin
        aw_taken_reg <= 1'b0;
      end
    end
  end

  // write data channel, independent of the address channel
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_WREADY <= 1'b0;
      w_taken_reg  <= 1'b0;
      wdata_reg    <= 32'h0000_0000;
      wstrb_reg    <= 4'h0;
    end else begin
      S_AXI_WREADY <= S_AXI_WVALID && !S_AXI_WREADY && !w_taken_reg && !loading;
      if (w_hs) begin
        w_taken_reg <= 1'b1;
        wdata_reg   <= S_AXI_WDATA;
        wstrb_reg   <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_taken_reg <= 1'b0;
      end
    end
  end

  // write response once both halves are held; read-only words ignore the data
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= RESP_OKAY;
    end else if (wr_fire) begin
      // the response wins over a ready seen in the same cycle
      S_AXI_BVALID <= 1'b1;
      S_AXI_BRESP  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      S_AXI_BVALID <= 1'b0;
    end
  end

  // software word pointer; a store data write leaves it where it is
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      store_addr_reg <= '0;
    end else if (wr_ptr) begin
      store_addr_reg <= ptr_next; // [RULE2]
    end
  end

  // read address channel; one read at a time, none while loading
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_ARREADY <= 1'b0;
      araddr_reg    <= 8'h00;
      rd_pipe_reg   <= 2'b00;
    end else begin
      // a second read waits until the first answer is taken
      S_AXI_ARREADY <= S_AXI_ARVALID && !S_AXI_ARREADY && !loading
                       && (rd_pipe_reg == 2'b00) && !S_AXI_RVALID;
      if (ar_hs) begin
        araddr_reg <= S_AXI_ARADDR;
      end
      // store read data settle one edge after the pointer, so wait two
      rd_pipe_reg <= {rd_pipe_reg[0], ar_hs};
    end
  end

  // read data channel
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0000_0000;
      S_AXI_RRESP  <= RESP_OKAY;
    end else if (rd_pipe_reg[1]) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA  <= is_mapped(araddr_reg) ? rd_mux : 32'h0000_0000;
      S_AXI_RRESP  <= is_mapped(araddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule // slave_info_eeprom_loader
`default_nettype wire

// ---- sim/slave_info_props.sv ----
// port-level checks on the power-up loader and its register window
// assumes one clock domain; bound onto every instance of the loader
`timescale 1ns/1ps
`default_nettype none
module slave_info_props import slave_info_pkg::*; (
  input wire logic        CLK,
  input wire logic        SYS_RST,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic [7:0]  S_AXI_ARADDR,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        LOAD_DONE,
  input wire logic [15:0] STATION_ALIAS
);
  // everything is judged at the rising edge, quiet while power is cycled
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  a_load_time: assert property ($fell(SYS_RST) |-> !LOAD_DONE [*8] ##[7:9] LOAD_DONE)
    else $error("load finish time wrong");
  a_alias_frozen: assert property (LOAD_DONE |=> LOAD_DONE && $stable(STATION_ALIAS))
    else $error("alias moved after load");
  a_alias_idle: assert property (!LOAD_DONE |-> STATION_ALIAS == 16'h0)
    else $error("alias set before load");
  a_bus_closed: assert property (!LOAD_DONE |-> !(S_AXI_AWREADY || S_AXI_WREADY || S_AXI_ARREADY))
    else $error("bus taken during load");
  a_read_lat: assert property (S_AXI_ARVALID && S_AXI_ARREADY |-> ##[3:4] S_AXI_RVALID)
    else $error("read answer late");
  a_unmapped_err: assert property (S_AXI_ARVALID && S_AXI_ARREADY && S_AXI_ARADDR >= OFS_LIMIT
    |-> ##[3:4] (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR && S_AXI_RDATA == 32'h0))
    else $error("unmapped read not refused");
  a_word_width: assert property (S_AXI_RVALID |-> S_AXI_RDATA[31:16] == 16'h0)
    else $error("read word wider than 16 bits");
  a_ar_pulse: assert property (S_AXI_ARREADY |=> !S_AXI_ARREADY)
    else $error("read ready held too long");
endmodule // slave_info_props
bind slave_info_eeprom_loader slave_info_props slave_info_props_inst (.CLK, .SYS_RST, .S_AXI_AWREADY,
  .S_AXI_WREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
  .S_AXI_RVALID, .LOAD_DONE, .STATION_ALIAS);
`default_nettype wire

// ---- sim/slave_info_model.sv ----
// behavioural image of the slave information store, word by word
// assumes the bench updates mem on every store write it makes
`timescale 1ns/1ps
`default_nettype none
module slave_info_model #(
  parameter logic [31:0] VID = 32'h0, // arbitrary value
  parameter logic [31:0] PC  = 32'h0,
  parameter logic [31:0] REV = 32'h0,
  parameter logic [31:0] SN  = 32'h0
);
  logic [15:0] mem [0:1023]; // 16 Kbit as 16-bit words

  // crc-8 over words 0..6, low byte first; kept in plain ints on purpose
  function automatic int crc();
    int c;
    c = 'hff;
    for (int w = 0; w < 7; w++) begin
      for (int b = 0; b < 2; b++) begin
        c = c ^ ((mem[w] >> (8 * b)) & 'hff);
        for (int i = 0; i < 8; i++) begin
          c = (c & 'h80) ? (((c << 1) ^ 'h07) & 'hff) : ((c << 1) & 'hff);
        end
      end
    end
    return c;
  endfunction

  // factory image
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 16'hffff; // erased categories
    mem[0] = 16'h0c05;
    mem[1] = 16'h6603;
    mem[2] = 16'h0064;
    mem[3] = 16'h0000;
    mem[4] = 16'h0000;
    mem[5] = 16'h0000;
    mem[6] = 16'h0000;
    mem[8] = VID[15:0];
    mem[9] = VID[31:16];
    mem[10] = PC[15:0];
    mem[11] = PC[31:16];
    mem[12] = REV[15:0];
    mem[13] = REV[31:16];
    mem[14] = SN[15:0];
    mem[15] = SN[31:16];
    mem[62] = 16'h000f;
    mem[63] = 16'h0001;
    mem[7] = 16'(crc());
  end
endmodule // slave_info_model
`default_nettype wire

// ---- sim/slave_info_eeprom_loader_tb.sv ----
// self-checking bench for the loader: axi4-lite master, store image model
// assumes the factory image holds a matching checksum at power-up
`timescale 1ns/1ps
`default_nettype none
module slave_info_eeprom_loader_tb import slave_info_pkg::*;;
  localparam logic [31:0] VID = 32'h1357_2468; // arbitrary value
  localparam logic [31:0] PC  = 32'h0000_0042;
  localparam logic [31:0] REV = 32'h0000_0003;
  localparam logic [31:0] SN  = 32'h0000_1001;
  logic        clk, rst, awv, wv, bready, arv, rready; // driven by the bench
  logic [7:0]  awa, ara;
  logic [31:0] wd;
  logic [3:0]  ws; // write strobes
  wire         awr, wr_rdy, bv, arr, rv, done; // seen from the design
  wire [1:0]   br, rr;
  wire [31:0]  rdat;
  wire [15:0]  alias_q;
  int          bad_count, n_checks, cyc;
  logic [9:0]  addrs [19] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 15, 62, 63, 64};
  logic [31:0] d;
  logic [1:0]  r;
  logic [15:0] na;

  slave_info_eeprom_loader #(.VENDOR_ID(VID), .PRODUCT_CODE(PC), .REVISION(REV), .SERIAL(SN))
    slave_info_eeprom_loader_inst (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWPROT(3'h0),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rready), .LOAD_DONE(done), .STATION_ALIAS(alias_q));
  slave_info_model #(.VID(VID), .PC(PC), .REV(REV), .SN(SN)) slave_info_model_inst ();

  // 25 MHz clock
  always #20 clk = ~clk;

  // hang guard, well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      end_sim();
    end
  end

  // one comparison, reported at once on mismatch
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      bad_count++;
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] dd, output logic [1:0] rs);
    @(posedge clk);
    awa <= a;
    wd <= dd;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wr_rdy) wv <= 1'b0;
    end while (!bv);
    rs = br;
    bready <= 1'b0;
  endtask

  // read: held until taken, answer taken at the rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rs);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end while (!rv);
    dd = rdat;
    rs = rr;
    rready <= 1'b0;
  endtask

  // store access through pointer and data window, word addressed
  task automatic sread(input logic [9:0] a, output logic [31:0] dd);
    logic [1:0] rs;
    wr(OFS_STORE_ADDR, {22'h0, a}, rs);
    rd(OFS_STORE_DATA, dd, rs);
  endtask

  task automatic swr(input logic [9:0] a, input logic [15:0] dd);
    logic [1:0] rs;
    wr(OFS_STORE_ADDR, {22'h0, a}, rs);
    wr(OFS_STORE_DATA, {16'h0, dd}, rs);
    slave_info_model_inst.mem[a] = dd;
  endtask

  // control power cycle; the load ends 16 edges after release
  task automatic power_cycle();
    @(posedge clk);
    rst <= 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (17) @(posedge clk);
    #1;
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {awv, wv, bready, arv, rready} = 5'h0;
    {awa, ara, wd} = 48'h0;
    ws = 4'hf;
    void'($urandom(74));
    power_cycle();
    chk("load_done", 32'h1, {31'h0, done});
    chk("alias_reset", 32'h0, {16'h0, alias_q});
    rd(OFS_STATUS, d, r);
    chk("status", 32'h6, d);
    foreach (addrs[i]) begin
      sread(addrs[i], d);
      if (addrs[i] == WA_CSUM) d = d & 32'hff;
      chk("store_word", {16'h0, slave_info_model_inst.mem[addrs[i]]}, d);
    end
    rd(OFS_IF_CTRL, d, r);
    chk("core_if_ctrl", {16'h0, CORE_IF_CTRL}, d);
    rd(OFS_IF_CFG, d, r);
    chk("core_if", {16'h0, CORE_IF_CFG}, d);
    rd(OFS_SYNC_PULSE, d, r);
    chk("core_sync", {16'h0, CORE_SYNC_PULSE}, d);
    rd(OFS_EXT_CFG, d, r);
    chk("core_ext", {16'h0, CORE_EXT_CFG}, d);
    rd(8'h20, d, r);
    chk("unmapped_rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(8'h24, 32'h5a5a, r);
    chk("unmapped_bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    wr(OFS_IF_CTRL, 32'h1234, r);
    rd(OFS_IF_CTRL, d, r);
    chk("core_ro", {16'h0, CORE_IF_CTRL}, d);
    // low byte lane only: the high byte of an erased category word survives
    ws <= 4'h1;
    wr(OFS_STORE_ADDR, {22'h0, WA_CATEGORY}, r);
    wr(OFS_STORE_DATA, 32'h0000_1234, r);
    ws <= 4'hf;
    slave_info_model_inst.mem[WA_CATEGORY][7:0] = 8'h34;
    sread(WA_CATEGORY, d);
    chk("byte_lane", {16'h0, slave_info_model_inst.mem[WA_CATEGORY]}, d);
    // new alias with matching checksum, plus a config word that must not leak
    na = 16'($urandom());
    swr(WA_IF_CTRL, 16'h0c04);
    swr(WA_ALIAS, na);
    swr(WA_CSUM, 16'(slave_info_model_inst.crc()));
    chk("alias_runtime", 32'h0, {16'h0, alias_q});
    rd(OFS_ALIAS, d, r);
    chk("alias_reg_runtime", 32'h0, d);
    power_cycle();
    chk("alias_loaded", {16'h0, na}, {16'h0, alias_q});
    rd(OFS_ALIAS, d, r);
    chk("alias_reg", {16'h0, na}, d);
    rd(OFS_IF_CTRL, d, r);
    chk("core_after_cycle", {16'h0, CORE_IF_CTRL}, d);
    // alias changed without its checksum: must load as zero
    swr(WA_ALIAS, na ^ 16'h0001);
    chk("alias_held", {16'h0, na}, {16'h0, alias_q});
    power_cycle();
    chk("alias_bad_sum", 32'h0, {16'h0, alias_q});
    rd(OFS_STATUS, d, r);
    chk("status_bad_sum", 32'h2, d);
    end_sim();
  end
endmodule // slave_info_eeprom_loader_tb
`default_nettype wire
